//--- hdl/wdt_cfg.svh
// constants of the watchdog: register byte offsets, field positions,
// reset values and counts; assumes a byte-addressed 32-bit register bus
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ==================== register byte offsets
`define WDT_OFS_CTRL0       8'h00
`define WDT_OFS_CTRL1       8'h04
`define WDT_OFS_KEY         8'h08
`define WDT_OFS_STATUS      8'h0c
`define WDT_OFS_MASK        8'h10
`define WDT_OFS_GLOBAL      8'h14
`define WDT_OFS_XIRQ_EN     8'he8

// ==================== field positions
`define WDT_B_RUN           7
`define WDT_B_CLR           6
`define WDT_B_FLAG          5
`define WDT_B_SLEEP_RUN     4
`define WDT_B_RST_FLAG      3
`define WDT_B_RST_PATH      0
`define WDT_B_WDOG_IRQ_EN   4
`define WDT_B_GLOBAL        0
`define WDT_XIRQ_WMASK      8'hf7

// ==================== reset values
`define WDT_RST_XIRQ_EN     8'h00
`define WDT_RST_SEL         3'h0
`define WDT_RST_CNT         6'h00

// ==================== timed access keys
`define WDT_KEY_FIRST       8'haa
`define WDT_KEY_SECOND      8'h55

// ==================== counts in rc clocks; interval count in divided ticks
`define WDT_INTERVAL_LAST   6'h3f
`define WDT_RESET_LAST      9'h1ff
`define WDT_PS_TERM_0       8'h00
`define WDT_PS_TERM_1       8'h01
`define WDT_PS_TERM_2       8'h07
`define WDT_PS_TERM_3       8'h0f
`define WDT_PS_TERM_4       8'h1f
`define WDT_PS_TERM_5       8'h3f
`define WDT_PS_TERM_6       8'h7f
`define WDT_PS_TERM_7       8'hff

`endif

//--- hdl/wdt_pkg.sv
// types shared by the watchdog modules
// assumes wdt_cfg.svh sits beside it
package wdt_pkg;

  // ==================== bus carriers
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avs_rsp_t;

  // ==================== timed access unlock progress
  typedef enum logic [1:0] {LOCK_CLOSED, LOCK_KEY1, LOCK_OPEN} unlock_state_t;

  // ==================== whole state of the watchdog top
  typedef struct packed {
    logic        wait_q;
    logic [31:0] rdata;
    unlock_state_t lock;
    logic        run_en;
    logic        clr_req;
    logic        flag;
    logic        sleep_run;
    logic        rst_flag;
    logic [2:0]  sel;
    logic        rst_path_en;
    logic [7:0]  xirq_en;
    logic        global_en;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic [5:0]  icnt;
    logic        armed;
    logic [8:0]  dcnt;
    logic        rc_q;
    logic        sleep_q;
    logic        irq_req;
    logic        irq;
    logic        wake;
    logic        sys_rst;
  } wd_state_t;

endpackage : wdt_pkg

//--- hdl/wdt_prescaler.sv
// selectable divider of rc clock ticks, 1/1 to 1/256
// assumes tick_i is a one-cycle pulse per rc clock edge
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module wdt_prescaler (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  // control
  input  wire logic       tick_i,
  input  wire logic       clear_i,
  input  wire logic [2:0] sel_i,
  // divided tick
  output logic            tick_o
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] term;

  // terminal count for each select code
  always_comb begin
    case (sel_i)
      3'h0:    term = `WDT_PS_TERM_0;
      3'h1:    term = `WDT_PS_TERM_1;
      3'h2:    term = `WDT_PS_TERM_2;
      3'h3:    term = `WDT_PS_TERM_3;
      3'h4:    term = `WDT_PS_TERM_4;
      3'h5:    term = `WDT_PS_TERM_5;
      3'h6:    term = `WDT_PS_TERM_6;
      default: term = `WDT_PS_TERM_7;
    endcase
  end

  // count ticks, wrap at the terminal count
  always_comb begin
    tick_o   = 1'b0;
    cnt_next = cnt_reg;
    if (clear_i) begin
      cnt_next = 8'h00;
    end else if (tick_i) begin
      if (cnt_reg >= term) begin
        cnt_next = 8'h00;
        tick_o   = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  // divider register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : wdt_prescaler

//--- hdl/wdt_top.sv
// watchdog timer with timed-access control, interrupt, wake and reset
// assumes rc_clk_i and cpu_sleep_i are synchronous to mclk_i and the
// rc clock is much slower than mclk_i; registers on Avalon-MM
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`include "wdt_cfg.svh"

// Overview of operation
// - select field picks divide 1 to 256
// - reset 512 rc clocks after uncleared timeout
// - enable register bit four gates watchdog interrupt
// - interrupt request needs watchdog and global enables
// - timeout flag set on each completed interval
// - counter clear restarts interval from zero
// - timeout wakes cpu when counting during sleep
// - run enable starts; clearing stops and zeroes
// - sleep run bit chooses halt or count
// - counter clear bit clears itself when done
// - reset path enable bit arms reset path
module wdt_top (
  // clock and reset
  input  wire logic            mclk_i,
  input  wire logic            nrst_i,
  // register bus
  input  wire wdt_pkg::avs_req_t avs_req_i,
  output wdt_pkg::avs_rsp_t    avs_rsp_o,
  // system side
  input  wire logic            rc_clk_i,
  input  wire logic            cpu_sleep_i,
  output logic                 irq_req_o,
  output logic                 irq_o,
  output logic                 wake_o,
  output logic                 sys_rst_o
);
  import wdt_pkg::*;

  wd_state_t   st_reg;
  wd_state_t   st_next;
  logic        rc_tick;
  logic        ps_tick;
  logic        cnt_clear;
  logic        counting;
  logic        tmo;
  logic        wr_acc;
  logic        unlocked;
  logic [31:0] wd;
  logic [31:0] rmux;

  // ==================== outputs, all from flops
  assign avs_rsp_o.readdata    = st_reg.rdata;
  assign avs_rsp_o.waitrequest = st_reg.wait_q;
  assign irq_req_o             = st_reg.irq_req;
  assign irq_o                 = st_reg.irq;
  assign wake_o                = st_reg.wake;
  assign sys_rst_o             = st_reg.sys_rst;

  // ==================== counting chain
  // rc clock edge as a one-cycle tick
  assign rc_tick   = rc_clk_i & ~st_reg.rc_q;
  // halt in sleep unless sleep run is set
  assign counting  = st_reg.run_en & ~(cpu_sleep_i & ~st_reg.sleep_run);
  // clear on request, on stop, and on sleep entry or exit
  assign cnt_clear = st_reg.clr_req | ~st_reg.run_en
                     | (cpu_sleep_i ^ st_reg.sleep_q);
  assign tmo       = ps_tick & (st_reg.icnt == `WDT_INTERVAL_LAST);

  // divider chosen by the select field
  wdt_prescaler u_prescaler (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .tick_i  (rc_tick & counting),
    .clear_i (cnt_clear),
    .sel_i   (st_reg.sel),
    .tick_o  (ps_tick)
  );

  // ==================== bus decode
  assign wr_acc   = avs_req_i.write & ~st_reg.wait_q;
  assign unlocked = (st_reg.lock == LOCK_OPEN);
  assign wd       = avs_req_i.writedata;

  // read multiplexer, unmapped reads give zero
  always_comb begin
    rmux = 32'h0000_0000;
    case (avs_req_i.address)
      `WDT_OFS_CTRL0: begin
        rmux[`WDT_B_RUN]       = st_reg.run_en;
        rmux[`WDT_B_CLR]       = st_reg.clr_req;
        rmux[`WDT_B_FLAG]      = st_reg.flag;
        rmux[`WDT_B_SLEEP_RUN] = st_reg.sleep_run;
        rmux[`WDT_B_RST_FLAG]  = st_reg.rst_flag;
        rmux[2:0]              = st_reg.sel;
      end
      `WDT_OFS_CTRL1:  rmux[`WDT_B_RST_PATH] = st_reg.rst_path_en;
      `WDT_OFS_STATUS: rmux[1:0] = st_reg.sts;
      `WDT_OFS_MASK:   rmux[1:0] = st_reg.msk;
      `WDT_OFS_GLOBAL: rmux[`WDT_B_GLOBAL] = st_reg.global_en;
      `WDT_OFS_XIRQ_EN: rmux[7:0] = st_reg.xirq_en;
      default:         rmux = 32'h0000_0000;
    endcase
  end

  // ==================== next state
  always_comb begin
    st_next         = st_reg;
    st_next.rc_q    = rc_clk_i;
    st_next.sleep_q = cpu_sleep_i;
    st_next.wake    = 1'b0;
    st_next.sys_rst = 1'b0;
    st_next.clr_req = 1'b0;

    // two-phase answer: one wait cycle, then the access edge
    if ((avs_req_i.read | avs_req_i.write) & st_reg.wait_q) begin
      st_next.wait_q = 1'b0;
      st_next.rdata  = rmux;
    end else begin
      st_next.wait_q = 1'b1;
    end

    // register writes
    if (wr_acc) begin
      case (avs_req_i.address)
        `WDT_OFS_KEY: begin
          // key sequence: first key, then second key
          if (wd[7:0] == `WDT_KEY_FIRST) begin
            st_next.lock = LOCK_KEY1;
          end else if (st_reg.lock == LOCK_KEY1 && wd[7:0] == `WDT_KEY_SECOND) begin
            st_next.lock = LOCK_OPEN;
          end else begin
            st_next.lock = LOCK_CLOSED;
          end
        end
        `WDT_OFS_CTRL0: begin
          st_next.lock = LOCK_CLOSED;
          if (unlocked) begin
            st_next.run_en    = wd[`WDT_B_RUN];
            st_next.clr_req   = wd[`WDT_B_CLR];
            st_next.sleep_run = wd[`WDT_B_SLEEP_RUN];
            st_next.sel       = wd[2:0];
            if (!wd[`WDT_B_FLAG]) begin
              st_next.flag = 1'b0;
            end
            if (!wd[`WDT_B_RST_FLAG]) begin
              st_next.rst_flag = 1'b0;
            end
          end
        end
        `WDT_OFS_CTRL1: begin
          st_next.lock = LOCK_CLOSED;
          if (unlocked) begin
            st_next.rst_path_en = wd[`WDT_B_RST_PATH];
          end
        end
        `WDT_OFS_STATUS: begin
          st_next.lock = LOCK_CLOSED;
          st_next.sts  = st_reg.sts & ~wd[1:0];
        end
        `WDT_OFS_MASK: begin
          st_next.lock = LOCK_CLOSED;
          st_next.msk  = wd[1:0];
        end
        `WDT_OFS_GLOBAL: begin
          st_next.lock      = LOCK_CLOSED;
          st_next.global_en = wd[`WDT_B_GLOBAL];
        end
        `WDT_OFS_XIRQ_EN: begin
          st_next.lock    = LOCK_CLOSED;
          st_next.xirq_en = wd[7:0] & `WDT_XIRQ_WMASK;
        end
        default: st_next.lock = LOCK_CLOSED;
      endcase
    end

    // interval counter
    if (cnt_clear) begin
      st_next.icnt = `WDT_RST_CNT;
    end else if (ps_tick) begin
      st_next.icnt = st_reg.icnt + 6'h01;
    end

    // reset delay: counter clear or stop cancels it
    if (st_reg.clr_req | ~st_reg.run_en | ~st_reg.rst_path_en) begin
      st_next.armed = 1'b0;
      st_next.dcnt  = 9'h000;
    end else if (st_reg.armed & rc_tick) begin
      st_next.dcnt = st_reg.dcnt + 9'h001;
      if (st_reg.dcnt == `WDT_RESET_LAST) begin
        st_next.armed    = 1'b0;
        st_next.dcnt     = 9'h000;
        st_next.sys_rst  = 1'b1;
        st_next.rst_flag = 1'b1;
        st_next.sts[1]   = 1'b1;
      end
    end

    // timeout events; sets win over software clears
    if (tmo) begin
      st_next.flag   = 1'b1;
      st_next.sts[0] = 1'b1;
      st_next.wake   = cpu_sleep_i & st_reg.sleep_run;
      if (st_reg.rst_path_en && !st_reg.armed) begin
        st_next.armed = 1'b1;
        st_next.dcnt  = 9'h000;
      end
    end

    // interrupt request to the cpu and summary interrupt
    st_next.irq_req = st_reg.flag & st_reg.xirq_en[`WDT_B_WDOG_IRQ_EN]
                      & st_reg.global_en;
    st_next.irq     = |(st_reg.sts & st_reg.msk);
  end

  // ==================== state register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg             <= '0;
      st_reg.wait_q      <= 1'b1;
      st_reg.lock        <= LOCK_CLOSED;
      st_reg.sel         <= `WDT_RST_SEL;
      st_reg.xirq_en     <= `WDT_RST_XIRQ_EN;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==================== assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // a completed interval
  sequence tmo_s;
    tmo;
  endsequence

  // cpu asleep with counting kept on
  sequence sleep_count_s;
    cpu_sleep_i && st_reg.sleep_run;
  endsequence

  // interrupt gating
  irq_gate_a: assert property (
    st_reg.flag && st_reg.xirq_en[`WDT_B_WDOG_IRQ_EN] && st_reg.global_en |=> irq_req_o)
    else $error("interrupt request missing with both enables set");
  irq_off_a: assert property (
    !st_reg.xirq_en[`WDT_B_WDOG_IRQ_EN] |=> !irq_req_o)
    else $error("interrupt request while watchdog enable clear");

  // timeout flag
  flag_set_a: assert property (
    tmo_s |=> st_reg.flag)
    else $error("timeout flag not set after timeout");
  flag_hold_a: assert property (
    st_reg.flag && !unlocked |=> st_reg.flag)
    else $error("timeout flag lost without unlocked write");

  // counter clear, stop and run gating
  clr_self_a: assert property (
    st_reg.clr_req |=> !st_reg.clr_req && st_reg.icnt == 6'h00)
    else $error("counter clear did not complete");
  clr_cancel_a: assert property (
    st_reg.clr_req |=> !st_reg.armed && st_reg.dcnt == 9'h000)
    else $error("counter clear left the reset delay running");
  stop_zero_a: assert property (
    !st_reg.run_en |=> st_reg.icnt == 6'h00 && !st_reg.armed)
    else $error("stopped counter not zero");
  run_gate_a: assert property (
    ps_tick |-> st_reg.run_en && !st_reg.clr_req)
    else $error("interval advanced while stopped or clearing");

  // sleep and wake
  halt_sleep_a: assert property (
    cpu_sleep_i && st_reg.sleep_q && !st_reg.sleep_run |=> $stable(st_reg.icnt))
    else $error("counter moved while halted in sleep");
  sleep_clear_a: assert property (
    cpu_sleep_i != st_reg.sleep_q |=> st_reg.icnt == 6'h00)
    else $error("counter not cleared on sleep entry or exit");
  wake_evt_a: assert property (
    tmo_s ##0 sleep_count_s |=> wake_o)
    else $error("no wake on timeout during sleep");
  wake_only_a: assert property (
    !(tmo && cpu_sleep_i && st_reg.sleep_run) |=> !wake_o)
    else $error("wake without a timeout during sleep");

  // reset delay path
  reset_fire_a: assert property (
    st_reg.armed && rc_tick && st_reg.dcnt == 9'h1ff && st_reg.run_en
    && st_reg.rst_path_en && !st_reg.clr_req |=> sys_rst_o ##1 !sys_rst_o)
    else $error("reset not issued at end of delay");
  rst_flag_a: assert property (
    sys_rst_o |-> st_reg.rst_flag && st_reg.sts[1])
    else $error("watchdog reset without its flags");
  reset_path_a: assert property (
    !st_reg.rst_path_en |=> !st_reg.armed ##1 !sys_rst_o)
    else $error("reset path active while disabled");

  // protected writes
  locked_write_a: assert property (
    wr_acc && avs_req_i.address == `WDT_OFS_CTRL1 && !unlocked |=> $stable(st_reg.rst_path_en))
    else $error("protected register changed without unlock");
  locked_run_a: assert property (
    wr_acc && avs_req_i.address == `WDT_OFS_CTRL0 && !unlocked
    |=> $stable(st_reg.run_en) && $stable(st_reg.sel))
    else $error("protected control changed without unlock");

endmodule : wdt_top

//--- verification/test_watchdog_timeout_reset_wakeup.sv
// testbench of the watchdog top: bus tasks, rc ticks, pulse counts
// assumes wdt_pkg and wdt_cfg.svh are compiled and on the include path
`timescale 1ns/1ps
`include "wdt_cfg.svh"

module test_watchdog_timeout_reset_wakeup;
  import wdt_pkg::*;
  // ==================== signals
  localparam logic [7:0] c0 = `WDT_OFS_CTRL0;
  localparam logic [7:0] c1 = `WDT_OFS_CTRL1;
  localparam logic [7:0] ky = `WDT_OFS_KEY;
  localparam logic [7:0] st = `WDT_OFS_STATUS;
  localparam logic [7:0] mk = `WDT_OFS_MASK;
  localparam logic [7:0] gl = `WDT_OFS_GLOBAL;
  localparam logic [7:0] ee = `WDT_OFS_XIRQ_EN;
  logic        mclk_i, nrst_i, rc_clk_i, cpu_sleep_i;
  logic        irq_req_o, irq_o, wake_o, sys_rst_o;
  avs_req_t    req;
  avs_rsp_t    rsp;
  logic [31:0] q;
  logic [7:0]  ofs [6] = '{c0, c1, st, mk, gl, ee};
  int          dv [3] = '{1, 2, 8};
  int          err_total, checked, cyc, n_rst, n_wake, i, k;

  // ==================== clock and design
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  wdt_top u_wdt_top (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .avs_req_i(req), .avs_rsp_o(rsp),
    .rc_clk_i(rc_clk_i), .cpu_sleep_i(cpu_sleep_i), .irq_req_o(irq_req_o),
    .irq_o(irq_o), .wake_o(wake_o), .sys_rst_o(sys_rst_o)
  );

  // pulse counts and cycle ceiling
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (sys_rst_o === 1'b1) n_rst <= n_rst + 1;
    if (wake_o === 1'b1) n_wake <= n_wake + 1;
    if (cyc == 40000) begin
      err_total++;
      finish_test();
    end
  end

  // ==================== tasks
  task finish_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  // one Avalon-MM access, held until waitrequest is sampled low
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk_i);
    req <= '{address: a, read: !w, write: w, writedata: d};
    do @(posedge mclk_i); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  // unlock keys then the protected write
  task pw(input logic [7:0] a, input logic [31:0] d);
    bus(ky, 1'b1, {24'h0, `WDT_KEY_FIRST});
    bus(ky, 1'b1, {24'h0, `WDT_KEY_SECOND});
    bus(a, 1'b1, d);
  endtask : pw

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // read a register and compare the masked bits
  task chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q & m, e);
  endtask : chk_reg

  // rc clock edges, high two cycles and low four
  task tick(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      rc_clk_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rc_clk_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
    end
  endtask : tick

  // ==================== main sequence
  initial begin
    nrst_i = 1'b0;
    rc_clk_i = 1'b0;
    cpu_sleep_i = 1'b0;
    req = '0;
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    // reset values, unmapped place, reserved bit
    for (i = 0; i < 6; i++) chk_reg(ofs[i], 32'hffffffff, 32'h0);
    bus(8'hfc, 1'b1, 32'hff);
    chk_reg(8'hfc, 32'hffffffff, 32'h0);
    bus(ee, 1'b1, 32'hff);
    chk_reg(ee, 32'hffffffff, 32'hf7);
    // writes without a proper unlock are ignored
    bus(c0, 1'b1, 32'h87);
    chk_reg(c0, 32'hffffffff, 32'h0);
    bus(ky, 1'b1, 32'h55);
    bus(ky, 1'b1, 32'haa);
    bus(c0, 1'b1, 32'h80);
    chk_reg(c0, 32'h80, 32'h0);
    bus(ky, 1'b1, 32'haa);
    bus(ky, 1'b1, 32'h55);
    bus(gl, 1'b1, 32'h0);
    bus(c0, 1'b1, 32'h80);
    chk_reg(c0, 32'h80, 32'h0);
    for (i = 0; i < 8; i++) begin
      pw(c0, 32'(i));
      chk_reg(c0, 32'h7, 32'(i));
    end
    // interval length for the first selects
    for (i = 0; i < 3; i++) begin
      pw(c0, 32'h0);
      pw(c0, 32'h80 | 32'(i));
      tick(64 * dv[i] - 1);
      chk_reg(c0, 32'h20, 32'h0);
      tick(1);
      chk_reg(c0, 32'h20, 32'h20);
    end
    // interrupt gating, status and mask
    bus(ee, 1'b1, 32'h10);
    chk_reg(gl, 32'h1, 32'h0);
    chk({31'h0, irq_req_o}, 32'h0);
    bus(gl, 1'b1, 32'h1);
    chk_reg(gl, 32'h1, 32'h1);
    chk({31'h0, irq_req_o}, 32'h1);
    bus(ee, 1'b1, 32'h0);
    chk_reg(ee, 32'hffffffff, 32'h0);
    chk({31'h0, irq_req_o}, 32'h0);
    chk_reg(st, 32'h1, 32'h1);
    bus(mk, 1'b1, 32'h1);
    chk_reg(mk, 32'h3, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    bus(st, 1'b1, 32'h1);
    chk_reg(st, 32'h1, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    // flag survives a one, clears on a protected zero
    pw(c0, 32'ha2);
    chk_reg(c0, 32'h20, 32'h20);
    pw(c0, 32'h82);
    chk_reg(c0, 32'h20, 32'h0);
    // restart by counter clear, then by run disable
    for (k = 0; k < 2; k++) begin
      pw(c0, 32'h0);
      pw(c0, 32'h80);
      tick(40);
      pw(c0, (k == 0) ? 32'hc0 : 32'h0);
      chk_reg(c0, 32'h40, 32'h0);
      pw(c0, 32'h80);
      tick(63);
      chk_reg(c0, 32'h20, 32'h0);
      tick(1);
      chk_reg(c0, 32'h20, 32'h20);
    end
    // sleep halts or keeps counting, wake on timeout
    chk(n_wake, 32'h0);
    pw(c0, 32'h0);
    pw(c0, 32'h80);
    tick(40);
    cpu_sleep_i <= 1'b1;
    tick(64);
    chk_reg(c0, 32'h20, 32'h0);
    cpu_sleep_i <= 1'b0;
    tick(63);
    chk_reg(c0, 32'h20, 32'h0);
    tick(1);
    chk_reg(c0, 32'h20, 32'h20);
    cpu_sleep_i <= 1'b1;
    pw(c0, 32'h0);
    pw(c0, 32'h90);
    k = n_wake;
    tick(64);
    chk_reg(c0, 32'h20, 32'h20);
    chk(n_wake, k + 1);
    cpu_sleep_i <= 1'b0;
    // reset 512 rc clocks after an uncleared timeout
    pw(c0, 32'h0);
    bus(c1, 1'b1, 32'h1);
    chk_reg(c1, 32'h1, 32'h0);
    pw(c1, 32'h1);
    chk_reg(c1, 32'h1, 32'h1);
    pw(c0, 32'h80);
    tick(64);
    k = n_rst;
    tick(511);
    chk(n_rst, k);
    tick(1);
    chk(n_rst, k + 1);
    chk_reg(c0, 32'h8, 32'h8);
    chk_reg(st, 32'h2, 32'h2);
    // reset path disabled gives no reset
    pw(c1, 32'h0);
    pw(c0, 32'h0);
    pw(c0, 32'h80);
    k = n_rst;
    tick(600);
    chk(n_rst, k);
    finish_test();
  end

endmodule : test_watchdog_timeout_reset_wakeup
